//--- verilog/dmru_params.svh
/*
  offsets, field positions, reset values and timing counts of the mode-register group.
  assumes inclusion by bare name from package and modules.
*/
`ifndef DMRU_PARAMS_SVH
`define DMRU_PARAMS_SVH
`define DMRU_ADDR_RUN_TIME 6'h17
`define DMRU_ADDR_ACT_CTRL 6'h18
`define DMRU_ADDR_REPAIR 6'h19
`define DMRU_ADDR_IGNORED 6'h1E
`define DMRU_STOP_OSC_OPCODE 7'h4D
`define DMRU_RUN_TIME_RESET 8'h00
`define DMRU_ACT_CTRL_RESET 8'h00
`define DMRU_TRR_EN_BIT 7
`define DMRU_TRR_BANK_HI 6
`define DMRU_TRR_BANK_LO 4
`define DMRU_UNLIMITED_BIT 3
`define DMRU_MAC_HI 2
`define DMRU_MAC_LO 0
`define DMRU_TICKS_PER_STEP 16
`define DMRU_LONG_RUN_CLOCKS 2048
`define DMRU_LONGER_RUN_CLOCKS 4096
`define DMRU_DUP_PARAM_RESET 8'h00
`endif

//--- verilog/dmru_pkg.sv
/*
  types shared by the mode-register group.
  assumes nothing beyond the params header.
*/
`include "dmru_params.svh"
package dmru_pkg;
  typedef logic [5:0] dmru_addr_t;
  typedef logic [7:0] dmru_byte_t;
  typedef enum logic [1:0] {DMRU_IDLE, DMRU_RUN_TIMED, DMRU_RUN_FREE} dmru_osc_state_t;
endpackage : dmru_pkg

//--- verilog/dmru_osc_timer.sv
/*
  dqs interval timer run control.
  assumes start/stop pulses synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dmru_params.svh"
module dmru_osc_timer
  import dmru_pkg::*;
#(
  parameter int CNT_W = 13
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic startPulse,
  input wire logic stopCmdPulse,
  input wire logic [7:0] runTime,
  output logic running,
  output logic [CNT_W-1:0] elapsed
);
  if (CNT_W < 13) begin : g_cnt_check
    $error("CNT_W too small for longest run");
  end

  typedef struct packed {
    dmru_osc_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] limit;
  } dmru_tmr_t;

  dmru_tmr_t s_reg;
  dmru_tmr_t s_next;

  function automatic logic [CNT_W-1:0] runLimit(input logic [7:0] code);
    logic [CNT_W-1:0] v;
    v = '0;
    if (code[7:6] == 2'b01) v = CNT_W'(`DMRU_LONG_RUN_CLOCKS);
    else if (code[7:6] == 2'b10) v = CNT_W'(`DMRU_LONGER_RUN_CLOCKS);
    else v = CNT_W'(code[5:0]) * CNT_W'(`DMRU_TICKS_PER_STEP);
    return v;
  endfunction : runLimit

  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      DMRU_IDLE: begin
        if (startPulse) begin
          s_next.cnt = '0;
          s_next.limit = runLimit(runTime);
          s_next.st = (runTime == 8'h00) ? DMRU_RUN_FREE : DMRU_RUN_TIMED; // RL5
        end
      end
      DMRU_RUN_TIMED: begin
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        if (s_next.cnt >= s_reg.limit) s_next.st = DMRU_IDLE; // RL4
      end
      DMRU_RUN_FREE: begin
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        if (stopCmdPulse) s_next.st = DMRU_IDLE; // RL5
      end
      // unused state code falls back to idle
      default: begin
        s_next.st = DMRU_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg.st <= DMRU_IDLE;
      s_reg.cnt <= '0;
      s_reg.limit <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign running = (s_reg.st != DMRU_IDLE);
  assign elapsed = s_reg.cnt;
endmodule : dmru_osc_timer
`default_nettype wire

//--- verilog/dmru_mode_regs.sv
/*
  mode-register group: run time, activate/refresh control, repair readout,
  ignored slot, and a duplicated set-point parameter.
  assumes decoded mode-register write/read and multi-purpose command pulses from the
  command decoder, and set-point select bits from the frequency set-point register.
*/
// What this block does
// [RL1] writes and reads of duplicated parameters use the copy chosen by write select
// [RL2] operation uses only the copy chosen by operate select
// [RL3] inactive copy ignored; changing it leaves operation untouched
// [RL4] timer stops after code*16, 2048 or 4096 clocks
// [RL5] run time zero: timer runs until stop-oscillator command
// [RL6] controller must not send stop-oscillator with nonzero run time
// [RL7] activate count field reads 000 unknown when unlimited is zero
// [RL8] unlimited bit one means no limit; count field reads zero
// [RL9] refresh enable defaults off; write-only bank field picks bank 0-7
// [RL10] repair readout: bit n set when bank n has a resource left
// [RL11] addresses 17h run time, 18h activate control, 19h repair
// [RL12] controller reads both count registers and combines them; no count register is readable here, the count is only on oscElapsed
// [RL13] writes leave read-only fields; reads return only readable fields
`timescale 1ns/1ns
`default_nettype none
`include "dmru_params.svh"
module dmru_mode_regs
  import dmru_pkg::*;
#(
  parameter int BANKS = 8,
  parameter int CNT_W = 13,
  parameter logic UNLIMITED_ACT = 1'b0,
  parameter logic [2:0] MAC_CODE = 3'h0,
  parameter logic [7:0] DUP_PARAM_ADDR = 8'h16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] writeData,
  input wire logic setPointWriteSelect,
  input wire logic setPointOperateSelect,
  input wire logic mpcStrobe,
  input wire logic [6:0] mpcOpcode,
  input wire logic oscStartPulse,
  input wire logic [BANKS-1:0] repairAvailable,
  output logic [7:0] readData,
  output logic readValid,
  output logic [7:0] activeDupParam,
  output logic rowRefreshEnable,
  output logic [2:0] rowRefreshBank,
  output logic unlimitedActivates,
  output logic oscRunning,
  output logic [CNT_W-1:0] oscElapsed,
  output logic stopIllegal
);
  if (BANKS != 8) begin : g_bank_check
    $error("BANKS must be 8");
  end
  if (UNLIMITED_ACT && MAC_CODE != 3'h0) begin : g_mac_check
    $error("MAC_CODE must be 0 when unlimited");
  end

  typedef struct packed {
    dmru_byte_t runTime;
    dmru_byte_t actCtrl;
    dmru_byte_t dup0;
    dmru_byte_t dup1;
    dmru_byte_t rdata;
    logic rvalid;
    logic illegal;
  } dmru_state_t;

  dmru_state_t s_reg;
  dmru_state_t s_next;
  logic stopPulse;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
    return a == target;
  endfunction : hit

  function automatic dmru_byte_t actReadValue();
    dmru_byte_t v;
    v = 8'h00;
    v[`DMRU_UNLIMITED_BIT] = UNLIMITED_ACT; // RL8
    v[`DMRU_MAC_HI:`DMRU_MAC_LO] = UNLIMITED_ACT ? 3'h0 : MAC_CODE; // RL7 RL8
    return v;
  endfunction : actReadValue

  assign stopPulse = mpcStrobe && (mpcOpcode == `DMRU_STOP_OSC_OPCODE);

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.illegal = 1'b0;
    if (writeStrobe) begin
      if (hit(regAddr, `DMRU_ADDR_RUN_TIME)) s_next.runTime = writeData; // RL11
      if (hit(regAddr, `DMRU_ADDR_ACT_CTRL)) begin
        // only the refresh enable and bank bits are writable
        s_next.actCtrl[`DMRU_TRR_EN_BIT] = writeData[`DMRU_TRR_EN_BIT]; // RL9 RL13
        s_next.actCtrl[`DMRU_TRR_BANK_HI:`DMRU_TRR_BANK_LO] =
          writeData[`DMRU_TRR_BANK_HI:`DMRU_TRR_BANK_LO]; // RL9
      end
      if (hit(regAddr, DUP_PARAM_ADDR[5:0])) begin
        if (setPointWriteSelect) s_next.dup1 = writeData; // RL1
        else s_next.dup0 = writeData; // RL1
      end
    end
    if (readStrobe) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 8'h00; // RL13
      if (hit(regAddr, `DMRU_ADDR_ACT_CTRL)) s_next.rdata = actReadValue(); // RL11 RL13
      if (hit(regAddr, `DMRU_ADDR_REPAIR)) s_next.rdata = repairAvailable; // RL10 RL11
      if (hit(regAddr, DUP_PARAM_ADDR[5:0])) s_next.rdata = setPointWriteSelect ? s_reg.dup1 : s_reg.dup0; // RL1
    end
    if (stopPulse && s_reg.runTime != 8'h00) s_next.illegal = 1'b1; // RL6
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_reg.runTime <= `DMRU_RUN_TIME_RESET;
      s_reg.actCtrl <= `DMRU_ACT_CTRL_RESET;
      s_reg.dup0 <= `DMRU_DUP_PARAM_RESET;
      s_reg.dup1 <= `DMRU_DUP_PARAM_RESET;
      s_reg.rdata <= 8'h00;
      s_reg.rvalid <= 1'b0;
      s_reg.illegal <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  dmru_osc_timer #(
    .CNT_W(CNT_W)
  ) oscTimer (
    .mclk(mclk),
    .reset(reset),
    .startPulse(oscStartPulse),
    .stopCmdPulse(stopPulse && s_reg.runTime == 8'h00),
    .runTime(s_reg.runTime),
    .running(oscRunning),
    .elapsed(oscElapsed)
  );

  assign activeDupParam = setPointOperateSelect ? s_reg.dup1 : s_reg.dup0; // RL2 RL3
  assign rowRefreshEnable = s_reg.actCtrl[`DMRU_TRR_EN_BIT]; // RL9
  assign rowRefreshBank = s_reg.actCtrl[`DMRU_TRR_BANK_HI:`DMRU_TRR_BANK_LO]; // RL9
  assign unlimitedActivates = UNLIMITED_ACT; // RL8
  assign readData = s_reg.rdata;
  assign readValid = s_reg.rvalid;
  assign stopIllegal = s_reg.illegal;
endmodule : dmru_mode_regs
`default_nettype wire

//--- bench/dmru_ctrl_model.sv
/* controller model: one mode-register or multi-purpose command per call; needs mclk */
`timescale 1ns/1ns
`default_nettype none
module dmru_ctrl_model
  import dmru_pkg::*;
(
  input wire logic mclk,
  output logic writeStrobe, readStrobe, mpcStrobe, oscStartPulse,
  output logic [5:0] regAddr,
  output logic [6:0] mpcOpcode,
  output logic [7:0] writeData
);
  initial {oscStartPulse, mpcStrobe, readStrobe, writeStrobe, regAddr, mpcOpcode, writeData} = 25'h0;
  // held over one rising edge; on release strobes drop low and address, opcode and data lines show the inverse
  task automatic issue(input logic [3:0] k, input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk);
    {oscStartPulse, mpcStrobe, readStrobe, writeStrobe, regAddr, mpcOpcode, writeData} = {k, a, d[6:0], d};
    @(negedge mclk);
    {oscStartPulse, mpcStrobe, readStrobe, writeStrobe, regAddr, mpcOpcode, writeData} = {4'h0, ~a, ~d[6:0], ~d};
  endtask : issue
endmodule : dmru_ctrl_model
`default_nettype wire

//--- bench/dmru_mode_regs_monitor.sv
/* checker for dmru_mode_regs; sees only its ports */
`timescale 1ns/1ns
`default_nettype none
module dmru_mode_regs_monitor
  import dmru_pkg::*;
(
  input wire logic mclk, reset, writeStrobe, readStrobe, mpcStrobe, oscStartPulse, oscRunning, stopIllegal,
  input wire logic readValid, setPointWriteSelect, setPointOperateSelect, rowRefreshEnable, unlimitedActivates,
  input wire logic [5:0] regAddr,
  input wire logic [6:0] mpcOpcode,
  input wire logic [7:0] writeData, repairAvailable, readData, activeDupParam,
  input wire logic [2:0] rowRefreshBank
);
  logic [7:0] runCode_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  always_ff @(posedge mclk)
    if (reset) runCode_reg <= 8'h00;
    else if (writeStrobe && regAddr == 6'h17) runCode_reg <= writeData;
  chk_repair_read: assert property (readStrobe && regAddr == 6'h19 |=> readValid && readData == $past(repairAvailable))
    else $error("bad repair read");
  chk_blank_read: assert property (readStrobe && regAddr inside {6'h17, 6'h1E, 6'h3F} |=> readData == 8'h00)
    else $error("bad blank read");
  chk_act_read: assert property (readStrobe && regAddr == 6'h18 |=> readData == {4'h0, unlimitedActivates, 3'h0})
    else $error("bad activate read");
  chk_trr_set: assert property (writeStrobe && regAddr == 6'h18 |=> {4'h0, rowRefreshEnable, rowRefreshBank} == $past(writeData) >> 4)
    else $error("bad refresh fields");
  chk_dup_write: assert property (writeStrobe && regAddr == 6'h16 && setPointWriteSelect == setPointOperateSelect
    ##1 $stable(setPointOperateSelect) |-> activeDupParam == $past(writeData)) else $error("bad active copy");
  chk_run_sixteen: assert property (oscStartPulse && !oscRunning && runCode_reg == 8'h01
    |=> oscRunning [*8] ##1 oscRunning [*8] ##1 !oscRunning) else $error("bad run length");
  chk_free_stop: assert property (oscRunning && runCode_reg == 8'h00 && mpcStrobe && mpcOpcode == 7'h4D |=> !oscRunning)
    else $error("stop not taken");
  chk_bad_stop: assert property (mpcStrobe && mpcOpcode == 7'h4D && runCode_reg != 8'h00 |=> stopIllegal)
    else $error("illegal stop not flagged");
endmodule : dmru_mode_regs_monitor
bind dmru_mode_regs dmru_mode_regs_monitor dmru_mode_regs_monitor_inst (.*);
`default_nettype wire

//--- bench/dram_mode_regs_upper_block_tb.sv
/* bench for dmru_mode_regs driven through the controller model */
`timescale 1ns/1ns
`default_nettype none
module dram_mode_regs_upper_block_tb;
  import dmru_pkg::*;
  logic mclk, reset, writeStrobe, readStrobe, mpcStrobe, oscStartPulse, oscRunning, stopIllegal, readValid;
  logic setPointWriteSelect, setPointOperateSelect, rowRefreshEnable, unlimitedActivates;
  logic [5:0] regAddr;
  logic [6:0] mpcOpcode;
  logic [7:0] writeData, repairAvailable, readData, activeDupParam;
  logic [2:0] rowRefreshBank;
  logic [12:0] oscElapsed;
  int failures = 0, nTests = 0, cycles = 0, n;
  dmru_mode_regs dmru_mode_regs_inst (.*);
  dmru_ctrl_model dmru_ctrl_model_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (++cycles == 20000) begin
    failures++;
    tally_and_finish();
  end
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : ck
  task automatic go(input logic [3:0] k, input logic [5:0] a, input logic [7:0] d);
    dmru_ctrl_model_inst.issue(k, a, d);
  endtask : go
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    go(4'h2, a, 8'h00);
    ck(16'({readValid, readData}), 16'({1'b1, e}));
  endtask : rd
  task automatic rst();
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    ck(16'({rowRefreshEnable, oscRunning, readValid}), 16'h0000);
  endtask : rst
  task automatic test_regs();
    repairAvailable = 8'hA5;
    rd(6'h19, 8'hA5);
    go(4'h1, 6'h19, 8'h00);
    go(4'h1, 6'h1E, 8'hFF);
    rd(6'h19, 8'hA5);
    rd(6'h1E, 8'h00);
    rd(6'h3F, 8'h00);
    for (int b = 0; b < 8; b++) begin
      go(4'h1, 6'h18, 8'h8F | 8'(b << 4));
      ck(16'({rowRefreshEnable, rowRefreshBank}), 16'(8 + b));
      rd(6'h18, 8'h00);
    end
    go(4'h1, 6'h18, 8'h30);
    ck(16'({rowRefreshEnable, rowRefreshBank}), 16'h0003);
    $display("register test done");
  endtask : test_regs
  task automatic test_setpoint();
    go(4'h1, 6'h16, 8'h11);
    setPointWriteSelect = 1'b1;
    go(4'h1, 6'h16, 8'h22);
    ck(16'(activeDupParam), 16'h0011);
    rd(6'h16, 8'h22);
    setPointOperateSelect = 1'b1;
    setPointWriteSelect = 1'b0;
    rd(6'h16, 8'h11);
    ck(16'(activeDupParam), 16'h0022);
    $display("set point test done");
  endtask : test_setpoint
  task automatic test_timer();
    logic [7:0] codes [5] = '{8'h01, 8'h3F, 8'h40, 8'h80, 8'hC2};
    int lens [5] = '{16, 1008, 2048, 4096, 32};
    foreach (codes[i]) begin
      go(4'h1, 6'h17, codes[i]);
      go(4'h8, 6'h00, 8'h00);
      n = 0;
      while (oscRunning === 1'b1 && n < 5000) begin
        @(negedge mclk);
        n++;
      end
      ck(16'(n), 16'(lens[i]));
      ck(16'(oscElapsed), 16'(lens[i]));
    end
    go(4'h1, 6'h17, 8'h00);
    go(4'h8, 6'h00, 8'h00);
    repeat (40) @(negedge mclk);
    ck(16'(oscRunning), 16'h0001);
    go(4'h4, 6'h00, 8'h4D);
    ck(16'({stopIllegal, oscRunning}), 16'h0000);
    go(4'h1, 6'h17, 8'h01);
    go(4'h8, 6'h00, 8'h00);
    go(4'h4, 6'h00, 8'h4D);
    ck(16'({stopIllegal, oscRunning}), 16'h0003);
    repeat (20) @(negedge mclk);
    ck(16'(oscRunning), 16'h0000);
    $display("timer test done");
  endtask : test_timer
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    setPointWriteSelect = 1'b0;
    setPointOperateSelect = 1'b0;
    repairAvailable = 8'h00;
    rst();
    test_regs();
    rst();
    test_setpoint();
    test_timer();
    tally_and_finish();
  end
endmodule : dram_mode_regs_upper_block_tb
`default_nettype wire
